// [design/dual_ramp_control.sv]
// register file and converter code control for two current outputs
// Behaviour
// - two channels, each with its own independent set of registers.
// - default ramp settings leave ramp limiting off, so output jumps straight to target.
// - mode bit 0 enables the channel; each channel set up separately.
// - mode bit 1 low keeps converter check on, high turns it off.
// - mode bits 4..7 pick range and resolution of the output value.
// - 0-20 mA over 0-65535 reads value unsigned, else signed.
// - slew bits 0-2 give step of 1 to 128 LSB, powers of two.
// - slew bits 8-11 pick one of sixteen update rates, default 152440 Hz.
// - slew bit 15 enables ramp limiting; clear means direct jumps.
// - ramping moves code toward target by at most step per tick.
// - default slew word is 514: 4 LSB step, default rate.
// - master writes in-range values; device then drives matching current.
// - default mode word 33 maps 0..32767 onto 4 to 20 mA.
//
// Added by the designer: strobed register access and the address map.
`timescale 1ns/100ps
`default_nettype none

module dual_ramp_control
	import dual_ramp_pkg::*;
#(
	parameter int unsigned CLK_HZ = CLK_HZ_DEFAULT
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [dual_ramp_pkg::ADDR_W-1:0] addr,
	input wire logic [dual_ramp_pkg::DATA_W-1:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [dual_ramp_pkg::DATA_W-1:0] rd_data,
	output logic [dual_ramp_pkg::DATA_W-1:0] code_ch1,
	output logic [dual_ramp_pkg::DATA_W-1:0] code_ch2,
	output logic [dual_ramp_pkg::MODE_SCALE_W-1:0] scale_ch1,
	output logic [dual_ramp_pkg::MODE_SCALE_W-1:0] scale_ch2,
	output logic enable_ch1,
	output logic enable_ch2,
	output logic check_en_ch1,
	output logic check_en_ch2
);

	import dual_ramp_pkg::*;

	logic [DATA_W-1:0] mode_q [NUM_CH];
	logic [DATA_W-1:0] mode_d [NUM_CH];
	logic [DATA_W-1:0] slew_q [NUM_CH];
	logic [DATA_W-1:0] slew_d [NUM_CH];
	logic [DATA_W-1:0] target_q [NUM_CH];
	logic [DATA_W-1:0] target_d [NUM_CH];
	logic [DATA_W-1:0] code [NUM_CH];
	logic [DATA_W-1:0] rd_data_q;
	logic [DATA_W-1:0] rd_data_d;
	logic [NUM_CH-1:0] hit_mode;
	logic [NUM_CH-1:0] hit_slew;
	logic [NUM_CH-1:0] hit_out;
	logic [NUM_CH-1:0] ok_value;

	// value is permissible for the selected scaling
	function automatic logic value_ok(input logic [15:0] mode,
		input logic [15:0] val);
		logic ok;
		ok = 1'b0;
		if (mode[MODE_S0_20W_BIT])
			ok = (val <= MAX_65535);
		else if (mode[MODE_S0_24_BIT])
			ok = !val[15] && (val <= MAX_24000);
		else
			ok = !val[15] && (val <= MAX_32767);
		return ok;
	endfunction : value_ok

	// address decode, three hits per channel
	always_comb
	begin
		hit_mode[0] = (addr == OFS_MODE_CH1);
		hit_mode[1] = (addr == OFS_MODE_CH2);
		hit_slew[0] = (addr == OFS_SLEW_CH1);
		hit_slew[1] = (addr == OFS_SLEW_CH2);
		hit_out[0] = (addr == OFS_OUT_CH1);
		hit_out[1] = (addr == OFS_OUT_CH2);
	end

	// configuration and target next values per channel
	always_comb
	begin
		for (int i = 0; i < NUM_CH; i++)
		begin
			mode_d[i] = mode_q[i];
			slew_d[i] = slew_q[i];
			target_d[i] = target_q[i];
			ok_value[i] = value_ok(mode_q[i], wr_data);
			// reserved bits are dropped so they always read zero
			if (wr_en && hit_mode[i])
				mode_d[i] = wr_data & MODE_WMASK;
			if (wr_en && hit_slew[i])
				slew_d[i] = wr_data & SLEW_WMASK;
			// out-of-range values are dropped, last target stays
			if (wr_en && hit_out[i] && ok_value[i])
				target_d[i] = wr_data;
			// a disabled channel forgets its target and takes no output writes
			if (!mode_q[i][MODE_EN_BIT])
				target_d[i] = OUT_RESET;
		end
	end

	// defaults give 4 to 20 mA and a 4 LSB / 152440 Hz ramp with limiting switched off
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < NUM_CH; i++)
			begin
				mode_q[i] <= MODE_RESET;
				slew_q[i] <= SLEW_RESET;
				target_q[i] <= OUT_RESET;
			end
		end
		else
		begin
			for (int i = 0; i < NUM_CH; i++)
			begin
				mode_q[i] <= mode_d[i];
				slew_q[i] <= slew_d[i];
				target_q[i] <= target_d[i];
			end
		end
	end

	// read mux; unmapped addresses answer zero
	always_comb
	begin
		rd_data_d = 16'h0000;
		if (rd_en)
		begin
			case (addr)
				OFS_MODE_CH1: rd_data_d = mode_q[0];
				OFS_MODE_CH2: rd_data_d = mode_q[1];
				OFS_SLEW_CH1: rd_data_d = slew_q[0];
				OFS_SLEW_CH2: rd_data_d = slew_q[1];
				OFS_OUT_CH1: rd_data_d = target_q[0];
				OFS_OUT_CH2: rd_data_d = target_q[1];
				OFS_CODE_CH1: rd_data_d = code[0];
				OFS_CODE_CH2: rd_data_d = code[1];
				default: rd_data_d = 16'h0000;
			endcase
		end
	end

	// read data stand only in the cycle after the strobe
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			rd_data_q <= 16'h0000;
		else
			rd_data_q <= rd_data_d;
	end

	assign rd_data = rd_data_q;

	// one slew limiter per channel, each fed only its own registers
	generate
		for (genvar g = 0; g < NUM_CH; g++)
		begin : g_ch
			ramp_channel #(
				.CLK_HZ(CLK_HZ)
			) u_ramp (
				.clk(clk),
				.rst_n(rst_n),
				.chan_en(mode_q[g][MODE_EN_BIT]),
				.ramp_en(slew_q[g][SLEW_RAMP_BIT]),
				.step_sel(slew_q[g][SLEW_STEP_LSB +: SLEW_STEP_W]),
				.rate_sel(slew_q[g][SLEW_RATE_LSB +: SLEW_RATE_W]),
				.target(target_q[g]),
				.code(code[g])
			);
		end
	endgenerate

	// converter-side controls, all straight from registers
	assign code_ch1 = code[0];
	assign code_ch2 = code[1];
	// one-hot selection is the master's duty; passed through as written
	assign scale_ch1 = mode_q[0][MODE_SCALE_LSB +: MODE_SCALE_W];
	assign scale_ch2 = mode_q[1][MODE_SCALE_LSB +: MODE_SCALE_W];
	assign enable_ch1 = mode_q[0][MODE_EN_BIT];
	assign enable_ch2 = mode_q[1][MODE_EN_BIT];
	assign check_en_ch1 = !mode_q[0][MODE_CHECK_OFF_BIT];
	assign check_en_ch2 = !mode_q[1][MODE_CHECK_OFF_BIT];

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	// one-cycle request shapes of the register port, built into the
	// multi-step checks so that back-to-back strobes are covered too
	sequence s_write_mode1;
		wr_en && addr == OFS_MODE_CH1;
	endsequence

	sequence s_read_mode1;
		rd_en && addr == OFS_MODE_CH1;
	endsequence

	a_mode_readback: assert property (
		s_write_mode1 ##1 s_read_mode1 |=>
		rd_data == ($past(wr_data, 2) & MODE_WMASK))
		else $error("mode word not read back as written");

	a_check_polarity: assert property (
		s_write_mode1 |=> check_en_ch1 == !$past(wr_data[MODE_CHECK_OFF_BIT]))
		else $error("check enable polarity wrong");

	a_disabled_ignore: assert property (
		!enable_ch1 && wr_en && addr == OFS_OUT_CH1 |=>
		target_q[0] == 16'h0000)
		else $error("disabled channel took an output write");

	a_range_reject: assert property (
		enable_ch1 && !mode_q[0][MODE_S0_20W_BIT] && wr_en &&
		addr == OFS_OUT_CH1 && wr_data[15] |=> $stable(target_q[0]))
		else $error("negative signed value accepted");

	a_unsigned_accept: assert property (
		enable_ch2 && mode_q[1][MODE_S0_20W_BIT] && wr_en &&
		addr == OFS_OUT_CH2 |=> target_q[1] == $past(wr_data))
		else $error("unsigned value not accepted");

	a_channels_apart: assert property (
		wr_en && addr == OFS_SLEW_CH1 |=> $stable(slew_q[1]))
		else $error("channel 1 write changed channel 2");

	a_read_zero: assert property (
		!rd_en |=> rd_data == 16'h0000)
		else $error("read data outside read answer cycle");

	sequence s_write_mode2;
		wr_en && addr == OFS_MODE_CH2;
	endsequence

	sequence s_read_mode2;
		rd_en && addr == OFS_MODE_CH2;
	endsequence

	// the second channel keeps its own mode word, read back the same way
	a_mode2_readback: assert property (
		s_write_mode2 ##1 s_read_mode2 |=>
		rd_data == ($past(wr_data, 2) & MODE_WMASK))
		else $error("channel 2 mode word not read back as written");

	a_check2_polarity: assert property (
		s_write_mode2 |=> check_en_ch2 == !$past(wr_data[MODE_CHECK_OFF_BIT]))
		else $error("channel 2 check enable polarity wrong");

	// the enable bit reaches the converter the cycle after the write
	a_enable_follow: assert property (
		s_write_mode1 |=> enable_ch1 == $past(wr_data[MODE_EN_BIT]))
		else $error("channel 1 enable does not follow mode word");

	// scaling bits go out as written; one-hot is left to the master
	a_scale2_follow: assert property (
		s_write_mode2 |=>
		scale_ch2 == $past(wr_data[MODE_SCALE_LSB +: MODE_SCALE_W]))
		else $error("channel 2 scaling bits not passed on");

	// reserved slew bits never reach the limiter
	a_slew_mask: assert property (
		wr_en && addr == OFS_SLEW_CH1 |=>
		slew_q[0] == ($past(wr_data) & SLEW_WMASK))
		else $error("slew word not stored through its mask");

	// an in-range value on an enabled channel in a 0..32767 scaling becomes the target
	a_value_accept: assert property (
		enable_ch1 && !mode_q[0][MODE_S0_20W_BIT] &&
		!mode_q[0][MODE_S0_24_BIT] && wr_en && addr == OFS_OUT_CH1 &&
		!wr_data[15] |=> target_q[0] == $past(wr_data))
		else $error("in-range output value not taken");

	// refused values leave the last target standing, never clamped
	a_sign_reject: assert property (
		enable_ch2 && !mode_q[1][MODE_S0_20W_BIT] && wr_en &&
		addr == OFS_OUT_CH2 && wr_data[15] |=> $stable(target_q[1]))
		else $error("channel 2 took a negative signed value");

	a_limit_reject: assert property (
		enable_ch2 && mode_q[1][MODE_S0_24_BIT] &&
		!mode_q[1][MODE_S0_20W_BIT] && wr_en && addr == OFS_OUT_CH2 &&
		wr_data > MAX_24000 |=> $stable(target_q[1]))
		else $error("value above the 0 to 24 mA limit accepted");

	a_disabled2_ignore: assert property (
		!enable_ch2 && wr_en && addr == OFS_OUT_CH2 |=>
		target_q[1] == 16'h0000)
		else $error("disabled channel 2 took an output write");

	// code readback answers with the code of the strobe cycle, so a
	// ramp step landing on that edge shows up one read later
	a_code1_readback: assert property (
		rd_en && addr == OFS_CODE_CH1 |=> rd_data == $past(code_ch1))
		else $error("channel 1 code readback wrong");

	a_code2_readback: assert property (
		rd_en && addr == OFS_CODE_CH2 |=> rd_data == $past(code_ch2))
		else $error("channel 2 code readback wrong");

endmodule : dual_ramp_control

`default_nettype wire

// [design/ramp_channel.sv]
// slew limiter for one converter channel
`timescale 1ns/100ps
`default_nettype none

module ramp_channel
	import dual_ramp_pkg::*;
#(
	parameter int unsigned CLK_HZ = CLK_HZ_DEFAULT
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic chan_en,
	input wire logic ramp_en,
	input wire logic [dual_ramp_pkg::SLEW_STEP_W-1:0] step_sel,
	input wire logic [dual_ramp_pkg::SLEW_RATE_W-1:0] rate_sel,
	input wire logic [dual_ramp_pkg::DATA_W-1:0] target,
	output logic [dual_ramp_pkg::DATA_W-1:0] code
);

	import dual_ramp_pkg::*;

	logic [31:0] cnt_q;
	logic [31:0] cnt_d;
	logic [31:0] period;
	logic tick;
	logic [DATA_W-1:0] code_q;
	logic [DATA_W-1:0] code_d;
	logic [DATA_W:0] step;
	logic [DATA_W-1:0] diff;

	// update period in clocks, rounded down, never below one
	function automatic logic [31:0] rate_cycles(input logic [3:0] sel);
		int unsigned c;
		c = CLK_HZ / RATE_HZ[sel];
		if (c == 0)
			c = 1;
		return 32'(c);
	endfunction : rate_cycles

	// update-rate tick; a rate change takes effect at once via >=
	always_comb
	begin
		period = rate_cycles(rate_sel);
		tick = (cnt_q >= period - 32'h0000_0001);
		cnt_d = tick ? 32'h0000_0000 : cnt_q + 32'h0000_0001;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			cnt_q <= 32'h0000_0000;
		else
			cnt_q <= cnt_d;
	end

	// step toward target, never overshooting it
	always_comb
	begin
		step = 17'h00001 << step_sel;
		diff = (target > code_q) ? target - code_q : code_q - target;
		code_d = code_q;
		if (!chan_en)
			code_d = 16'h0000;
		else if (!ramp_en)
			code_d = target;
		else if (tick)
		begin
			if ({1'b0, diff} <= step)
				code_d = target;
			else if (target > code_q)
				code_d = code_q + step[DATA_W-1:0];
			else
				code_d = code_q - step[DATA_W-1:0];
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			code_q <= 16'h0000;
		else
			code_q <= code_d;
	end

	assign code = code_q;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	a_disabled_zero: assert property (!chan_en |=> code == 16'h0000)
		else $error("disabled channel code not zero");

	a_jump_direct: assert property (
		chan_en && !ramp_en |=> code == $past(target))
		else $error("code did not jump to target");

	a_hold_between: assert property (
		chan_en && ramp_en && !tick |=> code == $past(code))
		else $error("code moved without update tick");

	a_step_bound: assert property (
		chan_en && ramp_en && tick && (code != target) |=>
		(code == $past(target)) ||
		(code == $past(code) + $past(step[DATA_W-1:0])) ||
		(code == $past(code) - $past(step[DATA_W-1:0])))
		else $error("ramp step size wrong");

endmodule : ramp_channel

`default_nettype wire

// [include/dual_ramp_pkg.sv]
// constants shared by the two-channel current output ramp control
package dual_ramp_pkg;

	// register port geometry
	localparam int ADDR_W = 9;
	localparam int DATA_W = 16;
	localparam int NUM_CH = 2;

	// register offsets on the register port
	localparam logic [8:0] OFS_OUT_CH1 = 9'h000;
	localparam logic [8:0] OFS_OUT_CH2 = 9'h002;
	localparam logic [8:0] OFS_MODE_CH1 = 9'h182;
	localparam logic [8:0] OFS_SLEW_CH1 = 9'h186;
	localparam logic [8:0] OFS_MODE_CH2 = 9'h18A;
	localparam logic [8:0] OFS_SLEW_CH2 = 9'h18E;
	localparam logic [8:0] OFS_CODE_CH1 = 9'h1A0;
	localparam logic [8:0] OFS_CODE_CH2 = 9'h1A2;

	// channel_mode fields
	localparam int MODE_EN_BIT = 0;
	localparam int MODE_CHECK_OFF_BIT = 1;
	localparam int MODE_SCALE_LSB = 4;
	localparam int MODE_SCALE_W = 4;
	localparam int MODE_S0_20_BIT = 4;
	localparam int MODE_S4_20_BIT = 5;
	localparam int MODE_S0_24_BIT = 6;
	localparam int MODE_S0_20W_BIT = 7;
	localparam logic [15:0] MODE_WMASK = 16'h00F3;

	// ramp_limit fields
	localparam int SLEW_STEP_LSB = 0;
	localparam int SLEW_STEP_W = 3;
	localparam int SLEW_RATE_LSB = 8;
	localparam int SLEW_RATE_W = 4;
	localparam int SLEW_RAMP_BIT = 15;
	localparam logic [15:0] SLEW_WMASK = 16'h8F07;

	// reset values
	localparam logic [15:0] MODE_RESET = 16'h0021;
	localparam logic [15:0] SLEW_RESET = 16'h0202;
	localparam logic [15:0] OUT_RESET = 16'h0000;

	// largest normalized value per scaling
	localparam logic [15:0] MAX_32767 = 16'h7FFF;
	localparam logic [15:0] MAX_24000 = 16'h5DC0;
	localparam logic [15:0] MAX_65535 = 16'hFFFF;

	// timing
	localparam int unsigned CLK_HZ_DEFAULT = 100_000_000;
	localparam int unsigned RAMP_FULL_SCALE_MS = 210;
	localparam int unsigned RATE_HZ [16] = '{
		257730, 198410, 152440, 131580, 115740, 69440, 37590, 25770,
		20160, 16030, 10290, 8280, 6900, 5530, 4240, 3300};

endpackage : dual_ramp_pkg

// [sim/bus_master.sv]
// register port master standing in for the fieldbus controller
`timescale 1ns/100ps
`default_nettype none

module bus_master
	import dual_ramp_pkg::*;
(
	input wire logic clk,
	output logic [dual_ramp_pkg::ADDR_W-1:0] addr,
	output logic [dual_ramp_pkg::DATA_W-1:0] wr_data,
	output logic wr_en,
	output logic rd_en,
	input wire logic [dual_ramp_pkg::DATA_W-1:0] rd_data
);
	// idle bus with both strobes low
	initial
	begin
		addr = '0;
		wr_data = '0;
		wr_en = 1'b0;
		rd_en = 1'b0;
	end

	// released lines show the inverse so stale values never pass
	task automatic write_reg(input logic [8:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
		addr <= ~a;
		wr_data <= ~d;
	endtask : write_reg

	// read data stand only in the cycle after the strobe
	task automatic read_reg(input logic [8:0] a, output logic [15:0] d);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		addr <= ~a;
		#1;
		d = rd_data;
	endtask : read_reg

	// write, then read the same word back in the very next cycle
	task automatic write_read(input logic [8:0] a, input logic [15:0] d,
		output logic [15:0] q);
		@(posedge clk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
		rd_en <= 1'b1;
		wr_data <= ~d;
		@(posedge clk);
		rd_en <= 1'b0;
		addr <= ~a;
		#1;
		q = rd_data;
	endtask : write_read
endmodule : bus_master

`default_nettype wire

// [sim/tb.sv]
// self-checking bench for the two-channel ramp control
`timescale 1ns/100ps
`default_nettype none

module tb;
	import dual_ramp_pkg::*;
	// short clock base keeps the slowest tick near 300 cycles
	localparam int unsigned CLK_HZ = 1000000;
	logic clk;
	logic rst_n;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wr_data, rd_data, code_ch1, code_ch2, rv, tgt;
	logic wr_en, rd_en, enable_ch1, enable_ch2, check_en_ch1, check_en_ch2;
	logic [MODE_SCALE_W-1:0] scale_ch1, scale_ch2;
	int mismatches;
	int num_checks;
	int n;
	logic [7:0] md [4] = '{8'h11, 8'h21, 8'h41, 8'h81};
	logic [15:0] lim [4] = '{16'h7FFF, 16'h7FFF, 16'h5DC0, 16'hFFFF};

	// free-running clock
	initial clk = 1'b0;
	always #5 clk = ~clk;

	dual_ramp_control #(.CLK_HZ(CLK_HZ)) dual_ramp_control_inst (
		.clk(clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
		.wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
		.code_ch1(code_ch1), .code_ch2(code_ch2),
		.scale_ch1(scale_ch1), .scale_ch2(scale_ch2),
		.enable_ch1(enable_ch1), .enable_ch2(enable_ch2),
		.check_en_ch1(check_en_ch1), .check_en_ch2(check_en_ch2));

	bus_master bus_master_inst (
		.clk(clk), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
		.rd_en(rd_en), .rd_data(rd_data));

	// verdict and end of run
	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_sim

	// compare a 16-bit result
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [8:0] a, input logic [15:0] d);
		bus_master_inst.write_reg(a, d);
	endtask : wr

	task automatic rdc(input logic [8:0] a, input logic [15:0] exp);
		bus_master_inst.read_reg(a, rv);
		chk(rv, exp);
	endtask : rdc

	// write and read back with no gap between the strobes
	task automatic wrc(input logic [8:0] a, input logic [15:0] d);
		bus_master_inst.write_read(a, d, rv);
		chk(rv, d);
	endtask : wrc

	// let the edge's updates land before sampling
	task automatic settle();
		@(posedge clk);
		#1;
	endtask : settle

	// packed view of the per-channel status outputs
	function automatic logic [15:0] stat();
		return {scale_ch1, scale_ch2, enable_ch1, enable_ch2,
			check_en_ch1, check_en_ch2, 4'h0};
	endfunction : stat

	// count cycles until ch1 code moves; a stuck code ends the run
	task automatic wait_move(output int k);
		logic [15:0] c;
		#1;
		c = code_ch1;
		k = 0;
		do
		begin
			settle();
			k++;
		end while (code_ch1 === c && k < 400);
		if (k >= 400)
		begin
			mismatches++;
			end_sim();
		end
	endtask : wait_move

	// main sequence
	initial
	begin
		rst_n = 1'b0;
		mismatches = 0;
		num_checks = 0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		chk(stat(), 16'h22F0);
		chk(code_ch1, 16'h0000);
		rdc(OFS_MODE_CH1, 16'h0021);
		rdc(OFS_MODE_CH2, 16'h0021);
		rdc(OFS_SLEW_CH1, 16'h0202);
		rdc(OFS_SLEW_CH2, 16'h0202);
		rdc(OFS_OUT_CH1, 16'h0000);
		$display("test reset done");
		wr(OFS_MODE_CH1, 16'h0023);
		settle();
		chk(stat(), 16'h22D0);
		rdc(OFS_MODE_CH1, 16'h0023);
		settle();
		chk(rd_data, 16'h0000);
		rdc(9'h100, 16'h0000);
		wrc(OFS_MODE_CH1, 16'h0021);
		chk(stat(), 16'h22F0);
		$display("test mode done");
		// ramp off: code follows the target one cycle later
		wr(OFS_SLEW_CH1, 16'h0002);
		tgt = 16'h1234;
		wr(OFS_OUT_CH1, tgt);
		settle();
		chk(code_ch1, tgt);
		wr(OFS_OUT_CH1, 16'h8000);
		settle();
		chk(code_ch1, tgt);
		$display("test jump done");
		// every rate code, steps cycling through all eight codes
		for (int r = 0; r < 16; r++)
		begin
			wr(OFS_SLEW_CH1, {1'b1, 3'h0, r[3:0], 5'h0, r[2:0]});
			tgt = tgt + (16'h0002 << r[2:0]);
			wr(OFS_OUT_CH1, tgt);
			wait_move(n);
			chk(code_ch1, tgt - (16'h0001 << r[2:0]));
			wait_move(n);
			chk(code_ch1, tgt);
			chk(16'(n), 16'(CLK_HZ / RATE_HZ[r]));
		end
		rdc(OFS_CODE_CH1, tgt);
		$display("test ramp done");
		// scaling modes on ch2: upper limit taken, one past it dropped for all but the 65535 mode
		for (int i = 0; i < 4; i++)
		begin
			wrc(OFS_MODE_CH2, {8'h00, md[i]});
			wr(OFS_OUT_CH2, lim[i]);
			settle();
			chk(code_ch2, lim[i]);
			chk({12'h000, scale_ch2}, {12'h000, md[i][7:4]});
			if (i < 3)
			begin
				wr(OFS_OUT_CH2, lim[i] + 16'h0001);
				settle();
				chk(code_ch2, lim[i]);
			end
		end
		chk(code_ch1, tgt);
		rdc(OFS_CODE_CH2, 16'hFFFF);
		$display("test scale done");
		wr(OFS_MODE_CH1, 16'h0020);
		settle();
		chk(code_ch1, 16'h0000);
		wr(OFS_OUT_CH1, 16'h0100);
		settle();
		settle();
		chk(code_ch1, 16'h0000);
		chk({15'h0, enable_ch1}, 16'h0000);
		wr(OFS_MODE_CH2, 16'h0080);
		wr(OFS_OUT_CH2, 16'h0010);
		settle();
		chk(code_ch2, 16'h0000);
		$display("test disable done");
		end_sim();
	end
endmodule : tb

`default_nettype wire
